/* hdl/blmsq_core.sv */
`timescale 1ns/100ps

// Functional notes
// - Lockout holds both gate outputs low
// - Lockout grounds timing node, oscillator stopped
// - Lockout clears preheat timer
// - Start on supply high and shutdown low
// - First pulse on low-side output
// - Preheat alternates outputs, equal on-times
// - Preheat timer advances linearly from entry
// - Early preheat ignores current sense
// - Timer past 7.5V enables protection
// - Preheat uses preheat on-time setting
// - Active output high during charge phase
// - Top of ramp starts discharge
// - Discharge phase is dead-time, both low
// - Bottom of ramp switches to other output
// - Timer past 13V enters ignition
// - Over-current after enable latches fault
// - Fault exits only to lockout
// - Bus low resets timer when enabled
module blmsq_core
  import blmsq_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire logic                        supply_on_in,
  input  wire logic                        supply_uv_in,
  input  wire logic                        shutdown_trip_in,
  input  wire logic                        shutdown_low_in,
  input  wire logic                        current_sense_in,
  input  wire logic                        bus_sense_low_in,
  input  wire logic [blmsq_pkg::ADR_W-1:0] reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  output logic                             high_side_gate_out,
  output logic                             low_side_gate_out,
  output logic                             charge_switch_out,
  output logic                             discharge_switch_out,
  output logic                             timing_cap_ground_out,
  output logic                             preheat_timer_ground_out,
  output logic                             protect_en_out,
  output blmsq_pkg::blmsq_state_t          mode_out
);
  import blmsq_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [SY_N-1:0]  sy1_r;
  logic [SY_N-1:0]  sy2_r;
  logic             sup_on_s;
  logic             sup_uv_s;
  logic             sd_trip_s;
  logic             sd_low_s;
  logic             cs_s;
  logic             bus_low_s;
  blmsq_state_t     state_r;
  blmsq_state_t     state_nxt;
  blmsq_phase_t     phase_r;
  blmsq_phase_t     phase_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             side_r;
  logic             side_nxt;
  logic [CNT_W-1:0] ph_on_r;
  logic [CNT_W-1:0] run_on_r;
  logic [CNT_W-1:0] dead_r;
  logic [15:0]      tmr_r;
  logic [15:0]      tick_r;
  logic             prot_en_r;
  logic             osc_nxt;
  logic             tmr_clr;

  function automatic logic is_osc(input blmsq_state_t s);
    is_osc = (s == ST_PH) || (s == ST_IGN);
  endfunction

  function automatic logic [CNT_W-1:0] on_len(
    input blmsq_state_t     s,
    input logic [CNT_W-1:0] ph,
    input logic [CNT_W-1:0] run
  );
    on_len = (s == ST_PH) ? ph : run;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // two-flop capture
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sy1_r <= '0;
      sy2_r <= '0;
    end
    else if (clk_en)
    begin
      sy1_r <= {bus_sense_low_in, current_sense_in, shutdown_low_in,
                shutdown_trip_in, supply_uv_in, supply_on_in};
      sy2_r <= sy1_r;
    end
  end

  assign sup_on_s  = sy2_r[SY_SUP_ON];
  assign sup_uv_s  = sy2_r[SY_SUP_UV];
  assign sd_trip_s = sy2_r[SY_SD_TRIP];
  assign sd_low_s  = sy2_r[SY_SD_LOW];
  assign cs_s      = sy2_r[SY_CS];
  assign bus_low_s = sy2_r[SY_BUS_LOW];

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // programmable counts
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ph_on_r  <= CNT_W'(PH_ON_CYC - 1);
      run_on_r <= CNT_W'(RUN_ON_CYC - 1);
      dead_r   <= CNT_W'(DEAD_CYC - 1);
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        REG_PH_ON:  ph_on_r  <= reg_wdata[CNT_W-1:0];
        REG_RUN_ON: run_on_r <= reg_wdata[CNT_W-1:0];
        REG_DEAD:   dead_r   <= reg_wdata[CNT_W-1:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        case (reg_addr)
          REG_PH_ON:  reg_rdata <= {16'h0000, ph_on_r};
          REG_RUN_ON: reg_rdata <= {16'h0000, run_on_r};
          REG_DEAD:   reg_rdata <= {16'h0000, dead_r};
          REG_STATUS: reg_rdata <= {11'h000, prot_en_r, side_r, phase_r,
                                    state_r, tmr_r};
          default:    reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_UNDERVOLTAGE_LOCKOUT_STATE:
        if (sup_on_s && sd_low_s && !sup_uv_s && !sd_trip_s)
          state_nxt = ST_PH;
      ST_PH:
        if (tmr_r > TMR_IGN_LVL)
          state_nxt = ST_IGN;
      ST_IGN:
        if (tmr_r <= TMR_IGN_LVL)
          state_nxt = ST_PH;
      ST_FAULT:
        state_nxt = ST_FAULT;
      default:
        state_nxt = ST_UNDERVOLTAGE_LOCKOUT_STATE;
    endcase
    if (is_osc(state_r) && prot_en_r && cs_s)
      state_nxt = ST_FAULT;
    if (sup_uv_s || sd_trip_s)
      state_nxt = ST_UNDERVOLTAGE_LOCKOUT_STATE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_r <= ST_UNDERVOLTAGE_LOCKOUT_STATE;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // ----------------------------------------
  // Oscillator
  // ----------------------------------------
  assign osc_nxt = is_osc(state_nxt);

  always_comb
  begin
    phase_nxt = phase_r;
    cnt_nxt   = cnt_r;
    side_nxt  = side_r;
    if (!osc_nxt)
    begin
      phase_nxt = PH_CHG;
      cnt_nxt   = '0;
      side_nxt  = 1'b0;
    end
    else if (!is_osc(state_r))
    begin
      phase_nxt = PH_CHG;
      cnt_nxt   = ph_on_r;
      side_nxt  = 1'b0;
    end
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
    else if (phase_r == PH_CHG)
    begin
      phase_nxt = PH_DIS;
      cnt_nxt   = dead_r;
    end
    else
    begin
      phase_nxt = PH_CHG;
      side_nxt  = ~side_r;
      cnt_nxt   = on_len(state_nxt, ph_on_r, run_on_r);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      phase_r <= PH_CHG;
      cnt_r   <= '0;
      side_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_r <= phase_nxt;
      cnt_r   <= cnt_nxt;
      side_r  <= side_nxt;
    end
  end

  // ----------------------------------------
  // Gate and switch outputs
  // ----------------------------------------
  // Built from next state so a trip drops gates on the same edge
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      high_side_gate_out    <= 1'b0;
      low_side_gate_out     <= 1'b0;
      charge_switch_out     <= 1'b0;
      discharge_switch_out  <= 1'b0;
      timing_cap_ground_out <= 1'b1;
      mode_out              <= ST_UNDERVOLTAGE_LOCKOUT_STATE;
    end
    else if (clk_en)
    begin
      high_side_gate_out    <= osc_nxt && phase_nxt == PH_CHG && side_nxt;
      low_side_gate_out     <= osc_nxt && phase_nxt == PH_CHG && !side_nxt;
      charge_switch_out     <= osc_nxt && phase_nxt == PH_CHG;
      discharge_switch_out  <= osc_nxt && phase_nxt == PH_DIS;
      timing_cap_ground_out <= !osc_nxt;
      mode_out              <= state_nxt;
    end
  end

  // ----------------------------------------
  // Preheat timer
  // ----------------------------------------
  // Bus check uses the enable already set, one cycle behind the timer
  assign tmr_clr = !osc_nxt || (prot_en_r && bus_low_s);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tmr_r  <= '0;
      tick_r <= '0;
    end
    else if (clk_en)
    begin
      if (tmr_clr)
      begin
        tmr_r  <= '0;
        tick_r <= '0;
      end
      else if (tick_r == 16'(TMR_STEP_CYC - 1))
      begin
        tick_r <= '0;
        if (tmr_r != TMR_MAX)
          tmr_r <= tmr_r + 1'b1;
      end
      else
        tick_r <= tick_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      prot_en_r                <= 1'b0;
      protect_en_out           <= 1'b0;
      preheat_timer_ground_out <= 1'b1;
    end
    else if (clk_en)
    begin
      prot_en_r                <= osc_nxt && tmr_r > TMR_PROT_LVL;
      protect_en_out           <= osc_nxt && tmr_r > TMR_PROT_LVL;
      preheat_timer_ground_out <= tmr_clr;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_undervoltage_lockout_state_gates;
    @(posedge ref_clk) disable iff (reset)
    state_r == ST_UNDERVOLTAGE_LOCKOUT_STATE |-> !high_side_gate_out && !low_side_gate_out;
  endproperty
  a_undervoltage_lockout_state_gates: assert property (p_undervoltage_lockout_state_gates)
    else $error("gate high in lockout");

  property p_undervoltage_lockout_state_ct;
    @(posedge ref_clk) disable iff (reset)
    state_r == ST_UNDERVOLTAGE_LOCKOUT_STATE |-> timing_cap_ground_out && !charge_switch_out;
  endproperty
  a_undervoltage_lockout_state_ct: assert property (p_undervoltage_lockout_state_ct)
    else $error("timing node not grounded in lockout");

  property p_undervoltage_lockout_state_tmr;
    @(posedge ref_clk) disable iff (reset)
    state_r == ST_UNDERVOLTAGE_LOCKOUT_STATE |-> tmr_r == 16'h0000 && preheat_timer_ground_out;
  endproperty
  a_undervoltage_lockout_state_tmr: assert property (p_undervoltage_lockout_state_tmr)
    else $error("preheat timer not cleared in lockout");

  property p_first_low;
    @(posedge ref_clk) disable iff (reset)
    (state_r == ST_PH && $past(state_r) == ST_UNDERVOLTAGE_LOCKOUT_STATE)
      |-> low_side_gate_out && !high_side_gate_out;
  endproperty
  a_first_low: assert property (p_first_low)
    else $error("first pulse not on low side");

  property p_no_overlap;
    @(posedge ref_clk) disable iff (reset)
    !(high_side_gate_out && low_side_gate_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both gates high");

  property p_dead_low;
    @(posedge ref_clk) disable iff (reset)
    discharge_switch_out |-> !high_side_gate_out && !low_side_gate_out;
  endproperty
  a_dead_low: assert property (p_dead_low)
    else $error("gate high during dead-time");

  property p_top_ramp;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && phase_r == PH_CHG && cnt_r == '0 && osc_nxt && is_osc(state_r))
      |=> discharge_switch_out && phase_r == PH_DIS;
  endproperty
  a_top_ramp: assert property (p_top_ramp)
    else $error("no discharge after on-time");

  property p_no_early_fault;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && !prot_en_r && state_r != ST_FAULT) |=> state_r != ST_FAULT;
  endproperty
  a_no_early_fault: assert property (p_no_early_fault)
    else $error("fault raised before protection enable");

  property p_oc_fault;
    @(posedge ref_clk) disable iff (reset)
    (clk_en && is_osc(state_r) && prot_en_r && cs_s && !sup_uv_s && !sd_trip_s)
      |=> state_r == ST_FAULT && !high_side_gate_out && !low_side_gate_out;
  endproperty
  a_oc_fault: assert property (p_oc_fault)
    else $error("over-current did not latch fault");

  property p_fault_exit;
    @(posedge ref_clk) disable iff (reset)
    (state_r == ST_FAULT && clk_en && !sup_uv_s && !sd_trip_s)
      |=> state_r == ST_FAULT;
  endproperty
  a_fault_exit: assert property (p_fault_exit)
    else $error("fault left without lockout cause");

endmodule

/* include/blmsq_pkg.sv */
package blmsq_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int DEAD_NS       = 2000;
  localparam int PH_ON_NS      = 7090;
  localparam int RUN_ON_NS     = 10500;
  localparam int TMR_STEP_NS   = 1000;
  localparam int DEAD_CYC      = DEAD_NS / CLK_PERIOD_NS;
  localparam int PH_ON_CYC     = PH_ON_NS / CLK_PERIOD_NS;
  localparam int RUN_ON_CYC    = RUN_ON_NS / CLK_PERIOD_NS;
  localparam int TMR_STEP_CYC  = (TMR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Widths and timer levels
  // ----------------------------------------
  localparam int CNT_W = 16;
  localparam int ADR_W = 4;
  localparam logic [15:0] TMR_PROT_LVL = 16'h02ee;
  localparam logic [15:0] TMR_IGN_LVL  = 16'h0514;
  localparam logic [15:0] TMR_MAX      = 16'hffff;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] REG_PH_ON  = 4'h0;
  localparam logic [3:0] REG_RUN_ON = 4'h4;
  localparam logic [3:0] REG_DEAD   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // ----------------------------------------
  // Synchroniser bit positions
  // ----------------------------------------
  localparam int SY_SUP_ON  = 0;
  localparam int SY_SUP_UV  = 1;
  localparam int SY_SD_TRIP = 2;
  localparam int SY_SD_LOW  = 3;
  localparam int SY_CS      = 4;
  localparam int SY_BUS_LOW = 5;
  localparam int SY_N       = 6;

  typedef enum logic [1:0] {
    ST_UNDERVOLTAGE_LOCKOUT_STATE  = 2'b00,
    ST_PH    = 2'b01,
    ST_IGN   = 2'b10,
    ST_FAULT = 2'b11
  } blmsq_state_t;

  typedef enum logic {
    PH_CHG = 1'b0,
    PH_DIS = 1'b1
  } blmsq_phase_t;

endpackage

/* test/blmsq_bridge.sv */
`timescale 1ns/100ps

// ----------------------------------------
// Half-bridge pair and lamp stand-in
// ----------------------------------------
module blmsq_bridge
(
  input  wire logic ref_clk,
  input  wire logic hi_gate,
  input  wire logic lo_gate,
  input  wire logic overload,
  output logic      sense_out
);
  // Sense resistor sits in the low leg, so only low-side or shoot-through current shows
  always_ff @(posedge ref_clk)
  begin
    sense_out <= lo_gate & (overload | hi_gate);
  end
endmodule

/* test/blmsq_core_tb.sv */
`timescale 1ns/100ps

module blmsq_core_tb;
  import blmsq_pkg::*;

  typedef struct packed
  {
    logic [31:0] val;
    logic [31:0] msk;
  } blmsq_note_t;

  logic             ref_clk, reset, clk_en, sup_on, sup_uv, sd_trip, sd_low;
  logic             cs, bus_low, overload, reg_wr, reg_rd;
  logic             hi, lo, chg, dis, ct_gnd, tm_gnd, prot, gchk, prev_hi, prev_lo;
  logic             pend = 1'b0;
  logic             first = 1'b1;
  logic             last_side = 1'b0;
  logic [ADR_W-1:0] reg_addr;
  logic [31:0]      reg_wdata, reg_rdata, seed, run, held;
  blmsq_state_t     mode;
  blmsq_note_t      notes[$];
  int               mismatches, n_compared, cycles, want_on, want_dead, i;
  int               run_len = 0;

  blmsq_core dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .supply_on_in(sup_on), .supply_uv_in(sup_uv), .shutdown_trip_in(sd_trip),
    .shutdown_low_in(sd_low), .current_sense_in(cs), .bus_sense_low_in(bus_low),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .high_side_gate_out(hi), .low_side_gate_out(lo),
    .charge_switch_out(chg), .discharge_switch_out(dis), .timing_cap_ground_out(ct_gnd),
    .preheat_timer_ground_out(tm_gnd), .protect_en_out(prot), .mode_out(mode));

  blmsq_bridge bridge_u (.ref_clk(ref_clk), .hi_gate(hi), .lo_gate(lo),
    .overload(overload), .sense_out(cs));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmode(input blmsq_state_t e);
    cmp(32'(mode), 32'(e));
  endtask

  task automatic close_out;
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Strobe dropped, then one idle edge, so no signal is assigned twice in a step
  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{v, m});
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // Watchers
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (pend)
    begin
      cmp(reg_rdata & notes[0].msk, notes[0].val);
      void'(notes.pop_front());
    end
    pend <= reg_rd & clk_en & ~reset;
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      close_out();
    end
  end

  // Pulse and gap lengths counted in samples of the settled gate levels
  always @(posedge ref_clk)
  begin
    prev_hi <= hi;
    prev_lo <= lo;
    run_len <= run_len + 1;
    // Charge while a gate is on, discharge in the gap
    if (gchk && (mode === ST_PH || mode === ST_IGN))
      cmp(32'({chg, dis}), (hi | lo) ? 32'h2 : 32'h1);
    if ({hi, lo} !== {prev_hi, prev_lo})
    begin
      run_len <= 1;
      if (gchk && {prev_hi, prev_lo} !== 2'b00 && {hi, lo} === 2'b00)
        cmp(32'(run_len), 32'(want_on + 1));
      if ({prev_hi, prev_lo} === 2'b00 && {hi, lo} !== 2'b00)
      begin
        if (first)
          cmp(32'({hi, lo}), 32'h1);
        else if (gchk)
        begin
          cmp(32'(run_len), 32'(want_dead + 1));
          cmp(32'({hi, lo}), last_side ? 32'h1 : 32'h2);
        end
        last_side <= hi;
        first     <= 1'b0;
      end
    end
    if (mode === ST_UNDERVOLTAGE_LOCKOUT_STATE)
      first <= 1'b1;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {reset, clk_en} = 2'b11;
    {sup_on, sup_uv, sd_trip, sd_low, bus_low, overload} = 6'h00;
    {reg_wr, reg_rd, gchk} = 3'b000;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0;
    mismatches = 0;
    n_compared = 0;
    cycles     = 0;
    seed       = xs(32'h00002203);
    run        = 32'(seed[2:0]) + 32'h4;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp(32'({hi, lo, ct_gnd, tm_gnd}), 32'h3);
    wr(REG_PH_ON, 32'h3);
    wr(REG_RUN_ON, run);
    wr(REG_DEAD, 32'h1);
    wr(4'h2, seed);
    rd(REG_PH_ON, 32'h3, 32'hffffffff);
    rd(REG_RUN_ON, run, 32'hffffffff);
    rd(REG_DEAD, 32'h1, 32'hffffffff);
    rd(4'h2, 32'h0, 32'hffffffff);
    rd(REG_STATUS, 32'h0, 32'h0013ffff);
    sup_on <= 1'b1;
    repeat (10) @(posedge ref_clk);
    cmode(ST_UNDERVOLTAGE_LOCKOUT_STATE);
    sd_low    <= 1'b1;
    want_on   <= 3;
    want_dead <= 1;
    gchk      <= 1'b1;
    for (i = 0; i < 6 && mode !== ST_PH; i++) @(posedge ref_clk);
    cmode(ST_PH);
    repeat (40) @(posedge ref_clk);
    overload <= 1'b1;
    repeat (30) @(posedge ref_clk);
    cmode(ST_PH);
    overload <= 1'b0;
    repeat (14700) @(posedge ref_clk);
    cmp(32'(prot), 32'h0);
    for (i = 0; i < 400 && prot !== 1'b1; i++) @(posedge ref_clk);
    cmp(32'(prot), 32'h1);
    rd(REG_STATUS, 32'h00110000, 32'h00130000);
    bus_low <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(REG_STATUS, 32'h00010000, 32'h0003fffe);
    bus_low <= 1'b0;
    gchk    <= 1'b0;
    repeat (25600) @(posedge ref_clk);
    cmode(ST_PH);
    for (i = 0; i < 800 && mode !== ST_IGN; i++) @(posedge ref_clk);
    cmode(ST_IGN);
    repeat (60) @(posedge ref_clk);
    want_on <= int'(run);
    gchk    <= 1'b1;
    repeat (100) @(posedge ref_clk);
    gchk     <= 1'b0;
    // Enable low must freeze gates and mode mid-cycle
    clk_en   <= 1'b0;
    @(posedge ref_clk);
    held = 32'({hi, lo, chg, dis, mode});
    repeat (12) @(posedge ref_clk);
    cmp(32'({hi, lo, chg, dis, mode}), held);
    clk_en   <= 1'b1;
    overload <= 1'b1;
    for (i = 0; i < 40 && mode !== ST_FAULT; i++) @(posedge ref_clk);
    cmode(ST_FAULT);
    cmp(32'({hi, lo, ct_gnd, tm_gnd}), 32'h3);
    overload <= 1'b0;
    repeat (20) @(posedge ref_clk);
    cmode(ST_FAULT);
    sd_low  <= 1'b0;
    sd_trip <= 1'b1;
    repeat (6) @(posedge ref_clk);
    cmode(ST_UNDERVOLTAGE_LOCKOUT_STATE);
    sd_trip <= 1'b0;
    sd_low  <= 1'b1;
    for (i = 0; i < 8 && mode !== ST_PH; i++) @(posedge ref_clk);
    cmode(ST_PH);
    repeat (20) @(posedge ref_clk);
    sup_on <= 1'b0;
    sup_uv <= 1'b1;
    repeat (6) @(posedge ref_clk);
    cmode(ST_UNDERVOLTAGE_LOCKOUT_STATE);
    cmp(32'({hi, lo, ct_gnd, tm_gnd}), 32'h3);
    repeat (4) @(posedge ref_clk);
    close_out();
  end
endmodule
